// File: bfr_defs.svh
// Constants for the burst flash read link: timing, command codes, field positions
`ifndef BFR_DEFS_SVH
`define BFR_DEFS_SVH

`define BFR_CLK_NS      100
`define BFR_PROG_NS     2000
`define BFR_PROG_CYC    ((`BFR_PROG_NS + `BFR_CLK_NS - 1) / `BFR_CLK_NS)
`define BFR_RST_NS      500
`define BFR_RST_CYC     ((`BFR_RST_NS + `BFR_CLK_NS - 1) / `BFR_CLK_NS)

`define BFR_BURST_LEN   32
`define BFR_CNT_W       5
`define BFR_CNT_LAST    5'h1f

`define BFR_CMD_UNLK1   16'h00aa
`define BFR_CMD_UNLK2   16'h0055
`define BFR_CMD_RESET   16'h00f0
`define BFR_CMD_PROG    16'h00a0
`define BFR_CMD_IDENT   16'h0090
`define BFR_CMD_BYPASS  16'h0020
`define BFR_CMD_ERASE   16'h0010
`define BFR_CMD_BEN     16'h00c0
`define BFR_CMD_BDIS    16'h00c8

`define BFR_ID_MFR_OFS  2'h0
`define BFR_ID_DEV_OFS  2'h1
`define BFR_ID_BST_OFS  2'h3
`define BFR_ST_POLL_BIT 7
`define BFR_ST_TOG_BIT  6

`endif

// File: bfr_pkg.sv
// Shared types of the burst flash read link
package bfr_pkg;
  timeunit 1ns;
  timeprecision 1ns;

  typedef enum logic [1:0]
  {
    BFR_C_IDLE  = 2'b00,
    BFR_C_UNLK1 = 2'b01,
    BFR_C_UNLK2 = 2'b11,
    BFR_C_PDATA = 2'b10
  } bfr_cmd_st_t;

  typedef enum logic [2:0]
  {
    BFR_H_IDLE  = 3'b000,
    BFR_H_RD    = 3'b001,
    BFR_H_WR    = 3'b011,
    BFR_H_BLOAD = 3'b010,
    BFR_H_BURST = 3'b110,
    BFR_H_RST   = 3'b111
  } bfr_host_st_t;

  typedef enum logic [1:0]
  {
    BFR_REQ_READ  = 2'h0,
    BFR_REQ_WRITE = 2'h1,
    BFR_REQ_BURST = 2'h2,
    BFR_REQ_HWRST = 2'h3
  } bfr_req_t;

endpackage

// File: bfr_if.sv
// Pin-level link between the host end and the flash end
interface bfr_if #(
  parameter int AW = 19,
  parameter int DW = 16
);
  timeunit 1ns;
  timeprecision 1ns;

  logic          ce_n;
  logic          oe_n;
  logic          we_n;
  logic          rst_pin_n;
  logic          load_start_addr_n;
  logic          advance_addr_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] dq_h;
  logic          dq_h_oe_n;
  logic [DW-1:0] dq_d;
  logic          dq_d_oe_n;
  logic          burst_last_word_n;
  logic [DW-1:0] dq;

  // Shared data wire; an undriven bus reads as all ones (pull-ups)
  assign dq = !dq_d_oe_n ? dq_d : (!dq_h_oe_n ? dq_h : {DW{1'b1}});

  modport host (
    output ce_n, oe_n, we_n, rst_pin_n, load_start_addr_n, advance_addr_n, addr, dq_h, dq_h_oe_n,
    input  dq, burst_last_word_n
  );

  modport dev (
    input  ce_n, oe_n, we_n, rst_pin_n, load_start_addr_n, advance_addr_n, addr, dq,
    output dq_d, dq_d_oe_n, burst_last_word_n
  );
endinterface

// File: bfr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module bfr_fifo #(
  parameter int W = 17,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wptr;
    logic [PW-1:0]       rptr;
    logic [CW-1:0]       count;
  } bfr_fifo_st_t;

  bfr_fifo_st_t r;
  bfr_fifo_st_t n;
  logic         push;
  logic         pop;

  assign in_ready  = (r.count != CW'(D));
  assign out_valid = (r.count != '0);
  assign out_data  = r.mem[r.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wptr] = in_data;
      n.wptr        = (r.wptr == PW'(D - 1)) ? '0 : r.wptr + 1'b1;
    end
    if (pop)
      n.rptr = (r.rptr == PW'(D - 1)) ? '0 : r.rptr + 1'b1;
    if (push && !pop)
      n.count = r.count + 1'b1;
    else if (pop && !push)
      n.count = r.count - 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else
      r <= n;
  end
endmodule

// File: bfr_flash.sv
// Flash end: asynchronous reads, command cycles and 32-word wrapping burst reads
`include "bfr_defs.svh"

// Notes on behaviour
// [R1] Host reads with select, gate low, strobe high
// [R2] Reset leaves array-read state, no command needed
// [R3] Async mode ignores clock, load and advance
// [R4] Host enables burst before any burst read
// [R5] Load strobe low one clock captures address
// [R6] Burst steps on clock edges; controls asynchronous
// [R7] Advance low steps address to next word
// [R8] Load clears 5-bit counter; advance increments
// [R9] Counter wraps to zero, starting word again
// [R10] Last-word flag low at counter value 11111b
// [R11] Advance high holds the current word
// [R12] Select high ends burst, keeps burst mode
// [R13] Burst disable command returns to async mode
// [R14] Reset pin aborts all, returns async mode
// [R15] Reset command keeps burst mode
// [R16] Gate and advance high: float, hold word
// [R17] Gate low alone shows same held word
// [R18] Gate and advance low step next word
// [R19] Host writes with select, strobe low, gate high
// [R20] Bypass mode programs in two cycles
// [R21] Identify mode reads codes on low byte
// [R22] Busy reads return status on low byte
// [R23] Counter touches only five low address bits
module bfr_flash import bfr_pkg::*; #(
  parameter int              AW      = 19,
  parameter int              DW      = 16,
  parameter int              MEM_AW  = 6,
  parameter logic [DW-1:0]   MFR_ID  = 16'h005a,  // Arbitrary value
  parameter logic [DW-1:0]   DEV_ID  = 16'h00c3   // Arbitrary value
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Pins
  bfr_if.dev        bus,
  // Status to local logic
  output logic      busy,
  output logic      burst_mode
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam int CW        = `BFR_CNT_W;

  typedef struct packed {
    logic [MEM_WORDS-1:0][DW-1:0] mem;
    bfr_cmd_st_t                  cst;
    logic                         burst_mode;
    logic                         active;
    logic [AW-1:0]                start;
    logic [CW-1:0]                cnt;
    logic                         ident;
    logic                         bypass;
    logic [15:0]                  busy_cnt;
    logic [DW-1:0]                pdata;
    logic                         tog;
    logic                         we_prev;
    logic                         oe_prev;
    logic [DW-1:0]                dout;
    logic                         last_n;
  } bfr_dev_state_t;

  bfr_dev_state_t r;
  bfr_dev_state_t n;
  logic           wr;
  logic [DW-1:0]  wd;
  logic [CW-1:0]  lo;
  logic [AW-1:0]  sel;
  logic [DW-1:0]  stat;
  logic [DW-1:0]  idw;

  assign busy       = (r.busy_cnt != '0);
  assign burst_mode = r.burst_mode;
  assign wd         = bus.dq;

  // A write is taken on the falling strobe with the gate high
  assign wr = !bus.ce_n && bus.oe_n && !bus.we_n && r.we_prev && bus.rst_pin_n && !busy;  // [R19]

  // Gate, select and strobe act without the clock; the reset pin floats the bus at once
  assign bus.dq_d_oe_n        = !(!bus.ce_n && !bus.oe_n && bus.we_n && bus.rst_pin_n);  // [R1] [R6] [R14] [R16]
  assign bus.dq_d             = r.dout;
  assign bus.burst_last_word_n = r.last_n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n         = r;
    lo        = '0;
    sel       = '0;
    stat      = '0;
    idw       = '0;
    n.we_prev = bus.we_n;
    n.oe_prev = bus.oe_n;
    if (!bus.rst_pin_n)
    begin
      // Array contents survive; an interrupted program is simply cut short
      n.cst        = BFR_C_IDLE;  // [R14] [R2]
      n.burst_mode = 1'b0;        // [R14]
      n.active     = 1'b0;
      n.cnt        = '0;
      n.ident      = 1'b0;
      n.bypass     = 1'b0;
      n.busy_cnt   = '0;
      n.dout       = '0;
      n.last_n     = 1'b1;
    end
    else
    begin
      if (busy)
        n.busy_cnt = r.busy_cnt - 1'b1;
      // Status toggle bit flips at the end of each read while busy
      if (busy && !r.oe_prev && bus.oe_n)
        n.tog = !r.tog;
      ////////////////////////////////////////////////////////////////////////
      if (wr)
      begin
        // Data of a program cycle is never taken as a command, whatever its value
        if (wd == `BFR_CMD_RESET && r.cst != BFR_C_PDATA)
        begin
          n.cst    = BFR_C_IDLE;  // [R15]
          n.ident  = 1'b0;
          n.bypass = 1'b0;
        end
        else
        begin
          case (r.cst)
            BFR_C_IDLE:
            begin
              if (wd == `BFR_CMD_UNLK1)
                n.cst = BFR_C_UNLK1;
              else if (r.bypass && wd == `BFR_CMD_PROG)
                n.cst = BFR_C_PDATA;  // [R20]
            end
            BFR_C_UNLK1:
              n.cst = (wd == `BFR_CMD_UNLK2) ? BFR_C_UNLK2 : BFR_C_IDLE;
            BFR_C_UNLK2:
            begin
              n.cst = BFR_C_IDLE;
              case (wd)
                `BFR_CMD_PROG:   n.cst = BFR_C_PDATA;
                `BFR_CMD_IDENT:  n.ident = 1'b1;  // [R21]
                `BFR_CMD_BYPASS: n.bypass = 1'b1;  // [R20]
                `BFR_CMD_BEN:    n.burst_mode = 1'b1;  // [R4]
                `BFR_CMD_BDIS:
                begin
                  n.burst_mode = 1'b0;  // [R13]
                  n.active     = 1'b0;  // [R13]
                end
                `BFR_CMD_ERASE:
                begin
                  for (int i = 0; i < MEM_WORDS; i++)
                    n.mem[i] = {DW{1'b1}};
                  n.pdata    = {DW{1'b1}};
                  n.busy_cnt = 16'(`BFR_PROG_CYC);
                end
                default:
                  n.cst = BFR_C_IDLE;
              endcase
            end
            BFR_C_PDATA:
            begin
              // Programming can only clear bits
              n.mem[bus.addr[MEM_AW-1:0]] = r.mem[bus.addr[MEM_AW-1:0]] & wd;
              n.pdata    = wd;
              n.busy_cnt = 16'(`BFR_PROG_CYC);
              n.cst      = BFR_C_IDLE;
            end
            default:
              n.cst = BFR_C_IDLE;
          endcase
        end
      end
      ////////////////////////////////////////////////////////////////////////
      // Burst sequencing only once enabled; otherwise load and advance are dead
      if (r.burst_mode && n.burst_mode)  // [R3] [R6]
      begin
        if (bus.ce_n)
          n.active = 1'b0;  // [R12]
        else if (!bus.load_start_addr_n)
        begin
          n.start  = bus.addr;  // [R5] [R12]
          n.cnt    = '0;        // [R8]
          n.active = 1'b1;
        end
        else if (r.active && !bus.advance_addr_n)
          n.cnt = r.cnt + 1'b1;  // [R7] [R8] [R9] [R18]
        // Advance high leaves the position alone, whatever the gate does  [R11] [R16] [R17]
      end
      ////////////////////////////////////////////////////////////////////////
      lo  = n.start[CW-1:0] + n.cnt;  // [R9] [R23]
      sel = n.active ? {n.start[AW-1:CW], lo} : bus.addr;  // [R23]
      stat = '0;
      stat[`BFR_ST_POLL_BIT] = !n.pdata[`BFR_ST_POLL_BIT];
      stat[`BFR_ST_TOG_BIT]  = n.tog;
      case (sel[1:0])
        `BFR_ID_MFR_OFS: idw = {8'h00, MFR_ID[7:0]};
        `BFR_ID_DEV_OFS: idw = {8'h00, DEV_ID[7:0]};
        `BFR_ID_BST_OFS: idw = {15'h0000, n.burst_mode};
        default:         idw = '0;
      endcase
      if (n.busy_cnt != '0)
        n.dout = stat;  // [R22]
      else if (n.ident)
        n.dout = idw;   // [R21]
      else
        n.dout = n.mem[sel[MEM_AW-1:0]];  // [R2]
      n.last_n = !(n.active && n.cnt == `BFR_CNT_LAST);  // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r         <= '0;
      r.we_prev <= 1'b1;
      r.oe_prev <= 1'b1;
      r.last_n  <= 1'b1;
    end
    else
      r <= n;
  end
endmodule

// File: bfr_host.sv
// Host end: runs read, write, burst and reset cycles and queues read words
`include "bfr_defs.svh"

module bfr_host import bfr_pkg::*; #(
  parameter int AW    = 19,
  parameter int DW    = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // Pins
  bfr_if.host                bus,
  // Requests
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire bfr_req_t      req_kind,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_data,
  input  wire logic [7:0]    req_len,
  // Read words, bit DW set on each word read with the last-word flag low (burst position 31)
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic [DW:0]        rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    bfr_host_st_t  st;
    logic [7:0]    ph;
    logic [7:0]    len;
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic          rst_n;
    logic          load_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          dq_oe_n;
  } bfr_host_state_t;

  bfr_host_state_t r;
  bfr_host_state_t n;
  logic            f_ready;
  logic            push;

  assign req_ready = (r.st == BFR_H_IDLE);

  // Gate and advance follow FIFO room so a full queue suspends the burst
  assign push = f_ready && ((r.st == BFR_H_BURST) || (r.st == BFR_H_RD && r.ph != '0));
  assign bus.advance_addr_n    = !(r.st == BFR_H_BURST && f_ready);  // [R16] [R18]
  assign bus.oe_n              = (r.st == BFR_H_BURST) ? !f_ready : r.oe_n;  // [R17]
  assign bus.ce_n              = r.ce_n;
  assign bus.we_n              = r.we_n;
  assign bus.rst_pin_n         = r.rst_n;
  assign bus.load_start_addr_n = r.load_n;
  assign bus.addr              = r.addr;
  assign bus.dq_h              = r.wdata;
  assign bus.dq_h_oe_n         = r.dq_oe_n;

  bfr_fifo #(
    .W (DW + 1),
    .D (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   ({!bus.burst_last_word_n, bus.dq}),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    case (r.st)
      BFR_H_IDLE:
      begin
        if (req_valid)
        begin
          n.addr  = req_addr;
          n.wdata = req_data;
          n.len   = req_len;
          n.ph    = '0;
          case (req_kind)
            BFR_REQ_READ:
            begin
              n.ce_n = 1'b0;  // [R1]
              n.oe_n = 1'b0;
              n.st   = BFR_H_RD;
            end
            BFR_REQ_WRITE:
            begin
              n.ce_n    = 1'b0;  // [R19]
              n.we_n    = 1'b0;
              n.dq_oe_n = 1'b0;
              n.st      = BFR_H_WR;
            end
            BFR_REQ_BURST:
            begin
              n.ce_n   = 1'b0;
              n.load_n = 1'b0;  // [R5]
              n.st     = BFR_H_BLOAD;
            end
            default:
            begin
              n.rst_n = 1'b0;
              n.st    = BFR_H_RST;
            end
          endcase
        end
      end
      BFR_H_RD:
      begin
        n.ph = 8'h01;
        if (push)
        begin
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.st   = BFR_H_IDLE;
        end
      end
      BFR_H_WR:
      begin
        n.ph = r.ph + 1'b1;
        n.we_n = 1'b1;
        if (r.ph != '0)
        begin
          n.ce_n    = 1'b1;
          n.dq_oe_n = 1'b1;
          n.st      = BFR_H_IDLE;
        end
      end
      BFR_H_BLOAD:
      begin
        n.load_n = 1'b1;  // [R5]
        n.st     = BFR_H_BURST;
      end
      BFR_H_BURST:
      begin
        if (push)
        begin
          n.ph = r.ph + 1'b1;
          if (r.ph + 8'h01 >= r.len)
          begin
            n.ce_n = 1'b1;  // [R12]
            n.st   = BFR_H_IDLE;
          end
        end
      end
      BFR_H_RST:
      begin
        n.ph = r.ph + 1'b1;
        if (r.ph == 8'(`BFR_RST_CYC - 1))
        begin
          n.rst_n = 1'b1;
          n.st    = BFR_H_IDLE;
        end
      end
      default:
        n.st = BFR_H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r         <= '0;
      r.st      <= BFR_H_IDLE;
      r.ce_n    <= 1'b1;
      r.oe_n    <= 1'b1;
      r.we_n    <= 1'b1;
      r.rst_n   <= 1'b1;
      r.load_n  <= 1'b1;
      r.dq_oe_n <= 1'b1;
    end
    else
      r <= n;
  end
endmodule

// File: bfr_chk.sv
// Pin-level assertions on the link between host end and flash end
module bfr_chk (
  // Clock and reset
  input  logic        clock,
  input  logic        nrst,
  // Host driven pins
  input  logic        ce_n,
  input  logic        oe_n,
  input  logic        we_n,
  input  logic        rst_pin_n,
  input  logic        load_start_addr_n,
  input  logic        advance_addr_n,
  input  logic [18:0] addr,
  // Flash driven pins
  input  logic [15:0] dq_d,
  input  logic        dq_d_oe_n,
  input  logic        burst_last_word_n
);
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed
  {
    logic        act;
    logic        cap;
    logic [4:0]  cnt;
    logic [15:0] first;
  } bfr_chk_st_t;

  bfr_chk_st_t st_r;
  bfr_chk_st_t st_nxt;
  logic        rd_pins;
  logic        ld;
  logic        adv;

  assign rd_pins = !ce_n && !oe_n && we_n && rst_pin_n;
  assign ld      = !ce_n && !load_start_addr_n && rst_pin_n;
  assign adv     = st_r.act && !ce_n && load_start_addr_n && !advance_addr_n && rst_pin_n;

  // Shadow of the burst position, so flag and wrap can be judged from the pins alone
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.cap = ld;
    if (st_r.cap)
      st_nxt.first = dq_d;
    if (adv)
      st_nxt.cnt = st_r.cnt + 5'h01;
    if (ld)
    begin
      st_nxt.act = 1'b1;
      st_nxt.cnt = 5'h00;
    end
    else if (ce_n || !rst_pin_n)
      st_nxt.act = 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_rst_float; !rst_pin_n |-> dq_d_oe_n; endproperty
  property p_drive; rd_pins |-> !dq_d_oe_n; endproperty
  property p_float; (ce_n || oe_n || !we_n) |-> dq_d_oe_n; endproperty
  property p_hold;
    st_r.act && !ce_n && load_start_addr_n && advance_addr_n && rst_pin_n |=> $stable(dq_d) && $stable(burst_last_word_n);
  endproperty
  property p_last; st_r.act |-> burst_last_word_n == (st_r.cnt != 5'h1f); endproperty
  property p_load; ld |=> burst_last_word_n; endproperty
  property p_wrap; adv && !burst_last_word_n |=> burst_last_word_n && dq_d == st_r.first; endproperty
  property p_async; !st_r.act && rd_pins && $past(rd_pins) && $stable(addr) |=> $stable(dq_d); endproperty

  a_rst_float: assert property (p_rst_float) else $error("data driven during link reset");
  a_drive: assert property (p_drive) else $error("data not driven in a read cycle");
  a_float: assert property (p_float) else $error("data driven outside a read cycle");
  a_hold: assert property (p_hold) else $error("burst word moved without advance");
  a_last: assert property (p_last) else $error("last word flag at wrong position");
  a_load: assert property (p_load) else $error("load did not clear position");
  a_wrap: assert property (p_wrap) else $error("wrap did not return the starting word");
  a_async: assert property (p_async) else $error("async word changed with steady pins");

  c_load: cover property (ld);
  c_wrap: cover property (adv && !burst_last_word_n);
  c_suspend: cover property (st_r.act && oe_n && advance_addr_n && !ce_n);
endmodule

// File: tb_burst_flash_read_interface.sv
// Testbench joining the host end and the flash end across the link
`include "bfr_defs.svh"

module tb_burst_flash_read_interface import bfr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] MFR = 16'h0036;  // Arbitrary value
  localparam logic [15:0] DEV = 16'h00e9;  // Arbitrary value

  logic        clock;
  logic        nrst;
  logic        req_valid;
  logic        req_ready;
  bfr_req_t    req_kind;
  logic [18:0] req_addr;
  logic [15:0] req_data;
  logic [7:0]  req_len;
  logic        rd_valid;
  logic        rd_ready;
  logic [16:0] rd_data;
  logic        busy;
  logic        burst_mode;
  logic        stall;
  logic [33:0] ent;
  logic [33:0] exp_q[$];
  logic [15:0] mem[64];
  int          seed = 38;
  int          num_errors = 0;
  int          checks = 0;

  bfr_if u_bfr_if ();
  bfr_host u_bfr_host (.clock(clock), .nrst(nrst), .bus(u_bfr_if.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr), .req_data(req_data),
    .req_len(req_len), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  bfr_flash #(.MFR_ID(MFR), .DEV_ID(DEV)) u_bfr_flash (.clock(clock), .nrst(nrst),
    .bus(u_bfr_if.dev), .busy(busy), .burst_mode(burst_mode));
  bfr_chk u_bfr_chk (.clock(clock), .nrst(nrst), .ce_n(u_bfr_if.ce_n), .oe_n(u_bfr_if.oe_n),
    .we_n(u_bfr_if.we_n), .rst_pin_n(u_bfr_if.rst_pin_n), .load_start_addr_n(u_bfr_if.load_start_addr_n),
    .advance_addr_n(u_bfr_if.advance_addr_n), .addr(u_bfr_if.addr), .dq_d(u_bfr_if.dq_d),
    .dq_d_oe_n(u_bfr_if.dq_d_oe_n), .burst_last_word_n(u_bfr_if.burst_last_word_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] expv);
    checks++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timeout();
    num_errors++;
    $display("BAD wait expected done seen timeout");
    final_report();
  endtask

  // Request is raised after an edge and held until the edge that takes it
  task automatic req(input bfr_req_t k, input logic [18:0] a, input logic [15:0] d, input logic [7:0] n);
    int i;
    @(posedge clock);
    #1 req_kind = k;
    {req_addr, req_data, req_len, req_valid} = {a, d, n, 1'b1};
    for (i = 0; i < 3000; i++)
    begin
      @(negedge clock);
      if (req_ready === 1'b1)
        break;
    end
    if (i == 3000)
      timeout();
    @(posedge clock);
    #1 req_valid = 1'b0;
  endtask

  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    req(BFR_REQ_WRITE, a, d, 8'h00);
  endtask

  task automatic cmd3(input logic [15:0] c);
    wr(19'h0, `BFR_CMD_UNLK1);
    wr(19'h0, `BFR_CMD_UNLK2);
    wr(19'h0, c);
  endtask

  task automatic rd(input logic [18:0] a, input logic [15:0] e, input logic [16:0] m);
    exp_q.push_back({m, 1'b0, e});
    req(BFR_REQ_READ, a, 16'h0, 8'h00);
  endtask

  task automatic burst(input logic [18:0] a, input int n);
    for (int k = 0; k < n; k++)
      exp_q.push_back({17'h1ffff, (k % 32) == 31, mem[{a[5], 5'(a[4:0] + k[4:0])}]});
    req(BFR_REQ_BURST, a, 16'h0, 8'(n));
  endtask

  task automatic idle();
    int i;
    repeat (3) @(posedge clock);
    for (i = 0; i < 3000; i++)
    begin
      @(negedge clock);
      if (req_ready === 1'b1 && busy === 1'b0 && exp_q.size() == 0)
        break;
    end
    if (i == 3000)
      timeout();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock)
    rd_ready <= #1 !stall && (($random(seed) & 3) != 0);

  // Each word leaving the host is matched to the oldest note
  always @(negedge clock)
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
    begin
      check("queued", {16'h0, exp_q.size() != 0}, 17'h1);
      if (exp_q.size() != 0)
      begin
        ent = exp_q.pop_front();
        check("rd_data", rd_data & ent[33:17], ent[16:0]);
      end
    end

  initial
  begin
    {nrst, stall, req_valid} = 3'b000;
    req_kind = BFR_REQ_READ;
    {req_addr, req_data, req_len} = '0;
    repeat (8) @(posedge clock);
    #1 nrst = 1'b1;
    rd(19'h05, 16'h0000, 17'h1ffff);
    cmd3(`BFR_CMD_ERASE);
    rd(19'h0, 16'h0000, 17'h1ffbf);
    idle();
    rd(19'h11, 16'hffff, 17'h1ffff);
    // Bypass keeps each program to two writes
    cmd3(`BFR_CMD_BYPASS);
    for (int a = 0; a < 64; a++)
    begin
      mem[a] = 16'($random(seed));
      wr(19'h0, `BFR_CMD_PROG);
      wr(19'(a), mem[a]);
      idle();
    end
    wr(19'h0, `BFR_CMD_RESET);
    for (int a = 0; a < 64; a += 9)
      rd(19'(a), mem[a], 17'h1ffff);
    cmd3(`BFR_CMD_IDENT);
    rd(19'h0, MFR & 16'h00ff, 17'h1ffff);
    rd(19'h1, DEV & 16'h00ff, 17'h1ffff);
    rd(19'h3, 16'h0000, 17'h1ffff);
    wr(19'h0, `BFR_CMD_RESET);
    cmd3(`BFR_CMD_BEN);
    idle();
    check("burst_mode", {16'h0, burst_mode}, 17'h1);
    wr(19'h0, `BFR_CMD_RESET);
    idle();
    check("burst_mode", {16'h0, burst_mode}, 17'h1);
    // Reader stalls so the buffer fills and the burst is suspended
    stall = 1'b1;
    burst({13'($random(seed)), 6'h3e}, 34);
    repeat (20) @(posedge clock);
    @(negedge clock);
    check("req_ready", {16'h0, req_ready}, 17'h0);
    stall = 1'b0;
    for (int j = 0; j < 4; j++)
      burst(19'($random(seed)), 1 + (($random(seed) & 32'h7fff) % 40));
    idle();
    cmd3(`BFR_CMD_BDIS);
    idle();
    check("burst_mode", {16'h0, burst_mode}, 17'h0);
    // Load and advance are dead in async mode: every word is the addressed one
    for (int k = 0; k < 5; k++)
      exp_q.push_back({17'h1ffff, 1'b0, mem[6'h15]});
    req(BFR_REQ_BURST, 19'h15, 16'h0, 8'h05);
    idle();
    rd(19'h2a, mem[6'h2a], 17'h1ffff);
    cmd3(`BFR_CMD_BEN);
    idle();
    req(BFR_REQ_HWRST, 19'h0, 16'h0, 8'h00);
    idle();
    check("burst_mode", {16'h0, burst_mode}, 17'h0);
    rd(19'h07, mem[6'h07], 17'h1ffff);
    idle();
    final_report();
  end
endmodule
